// >>> hdl/mpgio_pkg.sv
// Function
// RULE_01: Port zero: four pins, latch, per-bit direction
// RULE_02: Port zero pull-ups by shared option bit
// RULE_03: Key-return register also enables port zero pull-ups
// RULE_04: Reset puts every pin in input mode
// RULE_05: Port one: four pins, latch, per-bit direction
// RULE_06: Port one pull-ups by second shared bit
// RULE_07: Port two: seven pins, latch, per-bit direction
// RULE_08: Port two pull-ups enabled per bit
// RULE_09: Port two pins shared with serial, timer
// RULE_10: Software sets direction, latch before serial use
// RULE_11: Port three: four pins, latch, per-bit direction
// RULE_12: Port three pull-ups enabled per bit
// RULE_13: Port three shared with interrupts, capture, timers
// RULE_14: Port five: four open-drain pins, per-bit direction
// RULE_15: Port five pull-ups fixed by manufacturing option
// RULE_16: Flash variant has no port five pull-ups
// RULE_17: Twenty-three pins: nineteen push-pull, four open-drain
// RULE_18: Direction zero drives output, one is input
// RULE_19: Reset sets direction registers to all ones
// RULE_20: Outputs never get pull-ups, even alternate use
// RULE_21: Latch holds last write, drives pin in output
// RULE_22: Read returns pin for inputs, latch otherwise
// RULE_23: Open-drain pulls low only for latch zero

package mpgio_pkg;
  // ****************************************************************
  // Widths and pin vector layout
  // ****************************************************************
  localparam int REG_W      = 8;
  localparam int ADDR_W     = 18;
  localparam int NPINS      = 23;
  localparam int NPUSH      = 19;
  localparam int P0_LO      = 0;
  localparam int P1_LO      = 4;
  localparam int P2_LO      = 8;
  localparam int P3_LO      = 15;
  localparam int P5_LO      = 19;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [15:0] P0_LATCH_IDX = 16'hFF00;
  localparam logic [15:0] P1_LATCH_IDX = 16'hFF01;
  localparam logic [15:0] P2_LATCH_IDX = 16'hFF02;
  localparam logic [15:0] P3_LATCH_IDX = 16'hFF03;
  localparam logic [15:0] P5_LATCH_IDX = 16'hFF05;
  localparam logic [15:0] P0_DIR_IDX   = 16'hFF20;
  localparam logic [15:0] P1_DIR_IDX   = 16'hFF21;
  localparam logic [15:0] P2_DIR_IDX   = 16'hFF22;
  localparam logic [15:0] P3_DIR_IDX   = 16'hFF23;
  localparam logic [15:0] P5_DIR_IDX   = 16'hFF25;
  localparam logic [15:0] PORT_TWO_PULLUP_OPTION_IDX     = 16'hFF32;
  localparam logic [15:0] PORT_THREE_PULLUP_OPTION_IDX     = 16'hFF33;
  localparam logic [15:0] KRM_IDX      = 16'hFF60;
  localparam logic [15:0] PU0_IDX      = 16'hFFF7;

  // ****************************************************************
  // Reset values, field positions, responses
  // ****************************************************************
  localparam logic [7:0] DIR_RST   = 8'hFF;
  localparam logic [7:0] OPT_RST   = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam int         PU0_P0    = 0;
  localparam int         PU0_P1    = 1;
  localparam int         KRM_PU    = 0;
  localparam logic [7:0] PU0_MASK  = 8'h03;
  localparam logic [7:0] PORT_TWO_PULLUP_OPTION_MASK = 8'h7F;
  localparam logic [7:0] PORT_THREE_PULLUP_OPTION_MASK = 8'h0F;
  localparam logic [7:0] KRM_MASK  = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVE = 2'h2;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    return {idx, 2'h0};
  endfunction
endpackage

// >>> hdl/mpgio_top.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module mpgio_top #(
  parameter logic [3:0] P5_MASK_PULLUP = 4'h0,
  parameter bit         FLASH_VARIANT  = 1'b0
) (
  // Clock, reset, enable
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     ce,
  // AXI4-Lite write
  input  wire logic [mpgio_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [mpgio_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Port pins
  input  wire logic [3:0]               port_zero_pins_i,
  output logic [3:0]                    port_zero_pins_o,
  output logic [3:0]                    port_zero_pins_oe,
  output logic [3:0]                    port_zero_pullup,
  input  wire logic [3:0]               port_one_pins_i,
  output logic [3:0]                    port_one_pins_o,
  output logic [3:0]                    port_one_pins_oe,
  output logic [3:0]                    port_one_pullup,
  input  wire logic [6:0]               port_two_pins_i,
  output logic [6:0]                    port_two_pins_o,
  output logic [6:0]                    port_two_pins_oe,
  output logic [6:0]                    port_two_pullup,
  input  wire logic [3:0]               port_three_pins_i,
  output logic [3:0]                    port_three_pins_o,
  output logic [3:0]                    port_three_pins_oe,
  output logic [3:0]                    port_three_pullup,
  input  wire logic [3:0]               port_five_pins_i,
  output logic [3:0]                    port_five_pins_o,
  output logic [3:0]                    port_five_pins_oe,
  output logic [3:0]                    port_five_pullup,
  // Alternate outputs from peripherals
  input  wire logic [6:0]               port_two_alt_en,
  input  wire logic [6:0]               port_two_alt_out,
  input  wire logic [3:0]               port_three_alt_en,
  input  wire logic [3:0]               port_three_alt_out,
  // Alternate inputs to peripherals
  output logic [3:0]                    key_return_inputs,
  output logic                          serial_a_clock,
  output logic                          serial_a_in,
  output logic                          serial_b_clock,
  output logic                          serial_b_in,
  output logic [3:0]                    ext_interrupt_in,
  output logic                          capture_input,
  output logic                          timer_c_input
);
  import mpgio_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]        lat0_q, lat1_q, lat2_q, lat3_q, lat5_q;
  logic [7:0]        dir0_q, dir1_q, dir2_q, dir3_q, dir5_q;
  logic [7:0]        pu0_q, port_two_pullup_option_q, port_three_pullup_option_q, krm_q;
  logic [NPINS-1:0]  sync1_q, sync2_q;
  logic [NPUSH-1:0]  pin_o_q;
  logic [NPINS-1:0]  pin_oe_q, pull_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              aw_full_q, w_full_q;
  logic [7:0]        wdata_q;
  logic              wbyte_q;
  logic              bvalid_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [7:0]        rdata_q;

  // Pin value seen by software: input level or latch
  function automatic logic [7:0] rd_port(input logic [7:0] dir,
                                         input logic [7:0] lat,
                                         input logic [7:0] pin);
    return (dir & pin) | (~dir & lat);
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [NPINS-1:0] pins_raw = {port_five_pins_i, port_three_pins_i,
                               port_two_pins_i, port_one_pins_i,
                               port_zero_pins_i};
  wire [7:0] s0 = {4'h0, sync2_q[P1_LO-1:P0_LO]};
  wire [7:0] s1 = {4'h0, sync2_q[P2_LO-1:P1_LO]};
  wire [7:0] s2 = {1'b0, sync2_q[P3_LO-1:P2_LO]};
  wire [7:0] s3 = {4'h0, sync2_q[P5_LO-1:P3_LO]};
  wire [7:0] s5 = {4'h0, sync2_q[NPINS-1:P5_LO]};

  // ****************************************************************
  // AXI4-Lite decode
  // ****************************************************************
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire do_write = ce & aw_full_q & w_full_q & ~bvalid_q;
  wire wr_en    = do_write & wbyte_q;

  wire w_l0 = wr_en & (awaddr_q == byte_addr(P0_LATCH_IDX));
  wire w_l1 = wr_en & (awaddr_q == byte_addr(P1_LATCH_IDX));
  wire w_l2 = wr_en & (awaddr_q == byte_addr(P2_LATCH_IDX));
  wire w_l3 = wr_en & (awaddr_q == byte_addr(P3_LATCH_IDX));
  wire w_l5 = wr_en & (awaddr_q == byte_addr(P5_LATCH_IDX));
  wire w_d0 = wr_en & (awaddr_q == byte_addr(P0_DIR_IDX));
  wire w_d1 = wr_en & (awaddr_q == byte_addr(P1_DIR_IDX));
  wire w_d2 = wr_en & (awaddr_q == byte_addr(P2_DIR_IDX));
  wire w_d3 = wr_en & (awaddr_q == byte_addr(P3_DIR_IDX));
  wire w_d5 = wr_en & (awaddr_q == byte_addr(P5_DIR_IDX));
  wire w_pu = wr_en & (awaddr_q == byte_addr(PU0_IDX));
  wire w_b2 = wr_en & (awaddr_q == byte_addr(PORT_TWO_PULLUP_OPTION_IDX));
  wire w_b3 = wr_en & (awaddr_q == byte_addr(PORT_THREE_PULLUP_OPTION_IDX));
  wire w_kr = wr_en & (awaddr_q == byte_addr(KRM_IDX));
  wire w_hit = |{w_l0, w_l1, w_l2, w_l3, w_l5, w_d0, w_d1, w_d2, w_d3,
                 w_d5, w_pu, w_b2, w_b3, w_kr};
  wire aw_map = (awaddr_q[ADDR_W-1:2] inside {P0_LATCH_IDX, P1_LATCH_IDX,
                 P2_LATCH_IDX, P3_LATCH_IDX, P5_LATCH_IDX, P0_DIR_IDX,
                 P1_DIR_IDX, P2_DIR_IDX, P3_DIR_IDX, P5_DIR_IDX, PU0_IDX,
                 PORT_TWO_PULLUP_OPTION_IDX, PORT_THREE_PULLUP_OPTION_IDX, KRM_IDX}) & (awaddr_q[1:0] == 2'h0);

  // Unwritten direction bits above a port read as one
  logic [7:0] rd_val;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      byte_addr(P0_LATCH_IDX): rd_val = rd_port(dir0_q, lat0_q, s0); //RULE_22
      byte_addr(P1_LATCH_IDX): rd_val = rd_port(dir1_q, lat1_q, s1); //RULE_22
      byte_addr(P2_LATCH_IDX): rd_val = rd_port(dir2_q, lat2_q, s2); //RULE_22
      byte_addr(P3_LATCH_IDX): rd_val = rd_port(dir3_q, lat3_q, s3); //RULE_22
      byte_addr(P5_LATCH_IDX): rd_val = rd_port(dir5_q, lat5_q, s5); //RULE_22
      byte_addr(P0_DIR_IDX):   rd_val = dir0_q;
      byte_addr(P1_DIR_IDX):   rd_val = dir1_q;
      byte_addr(P2_DIR_IDX):   rd_val = dir2_q;
      byte_addr(P3_DIR_IDX):   rd_val = dir3_q;
      byte_addr(P5_DIR_IDX):   rd_val = dir5_q;
      byte_addr(PU0_IDX):      rd_val = pu0_q;
      byte_addr(PORT_TWO_PULLUP_OPTION_IDX):     rd_val = port_two_pullup_option_q;
      byte_addr(PORT_THREE_PULLUP_OPTION_IDX):     rd_val = port_three_pullup_option_q;
      byte_addr(KRM_IDX):      rd_val = krm_q;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Ready is low while ce is low so no AW, W or AR handshake slips past a freeze
  assign s_axi_awready = ce & ~aw_full_q;
  assign s_axi_wready  = ce & ~w_full_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h00_0000, rdata_q};

  // ****************************************************************
  // Pin drive computation
  // ****************************************************************
  // Alternate outputs override the latch; direction still gates drive
  wire [6:0] p2_val = (port_two_alt_en & port_two_alt_out)
                    | (~port_two_alt_en & lat2_q[6:0]);          //RULE_09
  wire [3:0] p3_val = (port_three_alt_en & port_three_alt_out)
                    | (~port_three_alt_en & lat3_q[3:0]);        //RULE_13
  wire [NPUSH-1:0] o_d = {p3_val, p2_val, lat1_q[3:0], lat0_q[3:0]};
  wire [3:0] p5_oe = ~dir5_q[3:0] & ~lat5_q[3:0];                //RULE_23
  wire [NPINS-1:0] oe_d = {p5_oe, ~dir3_q[3:0], ~dir2_q[6:0],
                           ~dir1_q[3:0], ~dir0_q[3:0]};          //RULE_18
  wire       p0_pu_on = pu0_q[PU0_P0] | krm_q[KRM_PU];          //RULE_03
  wire [3:0] p5_pu_on = FLASH_VARIANT ? 4'h0 : P5_MASK_PULLUP;   //RULE_16
  // Pull-up only on input-mode pins, regardless of alternate use
  wire [NPINS-1:0] pu_d = {
    dir5_q[3:0] & p5_pu_on,                                      //RULE_15
    dir3_q[3:0] & port_three_pullup_option_q[3:0],                                   //RULE_12
    dir2_q[6:0] & port_two_pullup_option_q[6:0],                                   //RULE_08
    dir1_q[3:0] & {4{pu0_q[PU0_P1]}},                            //RULE_06
    dir0_q[3:0] & {4{p0_pu_on}}};                                //RULE_02

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir0_q <= DIR_RST;                                         //RULE_19
      dir1_q <= DIR_RST;
      dir2_q <= DIR_RST;
      dir3_q <= DIR_RST;
      dir5_q <= DIR_RST;
      pu0_q  <= OPT_RST;
      port_two_pullup_option_q <= OPT_RST;
      port_three_pullup_option_q <= OPT_RST;
      krm_q  <= OPT_RST;
    end else if (ce) begin
      if (w_d0) dir0_q <= wdata_q | ~8'h0F;                      //RULE_01
      if (w_d1) dir1_q <= wdata_q | ~8'h0F;                      //RULE_05
      if (w_d2) dir2_q <= wdata_q | ~PORT_TWO_PULLUP_OPTION_MASK;                  //RULE_07
      if (w_d3) dir3_q <= wdata_q | ~8'h0F;                      //RULE_11
      if (w_d5) dir5_q <= wdata_q | ~8'h0F;                      //RULE_14
      if (w_pu) pu0_q  <= wdata_q & PU0_MASK;
      if (w_b2) port_two_pullup_option_q <= wdata_q & PORT_TWO_PULLUP_OPTION_MASK;
      if (w_b3) port_three_pullup_option_q <= wdata_q & PORT_THREE_PULLUP_OPTION_MASK;
      if (w_kr) krm_q  <= wdata_q & KRM_MASK;
    end
  end

  // Latches hold until the next write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat0_q <= LATCH_RST;
      lat1_q <= LATCH_RST;
      lat2_q <= LATCH_RST;
      lat3_q <= LATCH_RST;
      lat5_q <= LATCH_RST;
    end else if (ce) begin
      if (w_l0) lat0_q <= wdata_q & 8'h0F;                       //RULE_21
      if (w_l1) lat1_q <= wdata_q & 8'h0F;
      if (w_l2) lat2_q <= wdata_q & PORT_TWO_PULLUP_OPTION_MASK;
      if (w_l3) lat3_q <= wdata_q & 8'h0F;
      if (w_l5) lat5_q <= wdata_q & 8'h0F;
    end
  end

  // Pin drivers are registered; oe falls at the first clock edge with aresetn low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o_q  <= '0;
      pin_oe_q <= '0;                                            //RULE_04
      pull_q   <= '0;
      sync1_q  <= '0;
      sync2_q  <= '0;
    end else if (ce) begin
      pin_o_q  <= o_d;                                           //RULE_21
      pin_oe_q <= oe_d;                                          //RULE_20
      pull_q   <= pu_d;
      sync1_q  <= pins_raw;
      sync2_q  <= sync1_q;
    end
  end

  // AXI channel holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wbyte_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 8'h00;
    end else if (ce) begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wbyte_q  <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= aw_map ? RESP_OKAY : RESP_SLVE;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_val;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVE;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign port_zero_pins_o   = pin_o_q[P1_LO-1:P0_LO];
  assign port_one_pins_o    = pin_o_q[P2_LO-1:P1_LO];
  assign port_two_pins_o    = pin_o_q[P3_LO-1:P2_LO];
  assign port_three_pins_o  = pin_o_q[P5_LO-1:P3_LO];
  assign port_five_pins_o   = 4'h0;                              //RULE_17
  assign port_zero_pins_oe  = pin_oe_q[P1_LO-1:P0_LO];
  assign port_one_pins_oe   = pin_oe_q[P2_LO-1:P1_LO];
  assign port_two_pins_oe   = pin_oe_q[P3_LO-1:P2_LO];
  assign port_three_pins_oe = pin_oe_q[P5_LO-1:P3_LO];
  assign port_five_pins_oe  = pin_oe_q[NPINS-1:P5_LO];
  assign port_zero_pullup   = pull_q[P1_LO-1:P0_LO];
  assign port_one_pullup    = pull_q[P2_LO-1:P1_LO];
  assign port_two_pullup    = pull_q[P3_LO-1:P2_LO];
  assign port_three_pullup  = pull_q[P5_LO-1:P3_LO];
  assign port_five_pullup   = pull_q[NPINS-1:P5_LO];
  assign key_return_inputs  = s0[3:0];
  assign serial_a_clock     = s2[0];
  assign serial_a_in        = s2[2];
  assign serial_b_clock     = s2[3];
  assign serial_b_in        = s2[5];
  assign ext_interrupt_in   = s3[3:0];
  assign capture_input      = s3[0];
  assign timer_c_input      = s3[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_all_input: assert property (
    @(posedge aclk) disable iff (1'b0) !aresetn |=> (pin_oe_q == '0))
    else $error("pin driven after reset");                       //RULE_04
  a_reset_dir_ones: assert property (
    @(posedge aclk) disable iff (1'b0) !aresetn |=> (dir2_q == DIR_RST))
    else $error("direction not all ones after reset");           //RULE_19
  a_dir_drives_oe: assert property ($past(ce) |->
    port_one_pins_oe == ~$past(dir1_q[3:0]))
    else $error("oe does not follow direction");                 //RULE_18
  a_out_no_pullup: assert property (
    (port_two_pins_oe & port_two_pullup) == 7'h00)
    else $error("pull-up on output pin");                        //RULE_20
  a_p0_pull_group: assert property (ce && krm_q[KRM_PU] |=>
    (port_zero_pullup == $past(dir0_q[3:0])))
    else $error("key-return pull-up missing");                   //RULE_03
  a_p3_pull_bit: assert property ($past(ce) |->
    port_three_pullup == ($past(dir3_q[3:0]) & $past(port_three_pullup_option_q[3:0])))
    else $error("port three pull-up wrong");                     //RULE_12
  a_od_low_only: assert property (
    ((port_five_pins_oe & ~port_five_pins_o) == port_five_pins_oe))
    else $error("open-drain drives high");                       //RULE_23
  a_od_latch_one: assert property ($past(ce) && $past(lat5_q[0]) |->
    !port_five_pins_oe[0])
    else $error("open-drain pulls with latch one");              //RULE_23
  a_latch_to_pin: assert property (w_l1 ##1 ce |=>
    port_one_pins_o == $past(lat1_q[3:0]))
    else $error("latch not on pin");                             //RULE_21
  a_latch_holds: assert property (!w_l0 |=> $stable(lat0_q))
    else $error("latch changed without write");                  //RULE_21
  a_flash_no_pull: assert property (FLASH_VARIANT |->
    port_five_pullup == 4'h0)
    else $error("flash variant has port five pull-up");          //RULE_16
  a_read_input: assert property (ar_take && rd_hit &&
    s_axi_araddr == byte_addr(P2_LATCH_IDX) |=>
    rdata_q == rd_port($past(dir2_q), $past(lat2_q), $past(s2)))
    else $error("port read value wrong");                        //RULE_22

  c_write_resp: cover property (do_write ##[1:4] s_axi_bvalid);
  c_read_resp:  cover property (ar_take ##1 s_axi_rvalid);
  c_p0_output:  cover property (port_zero_pins_oe != 4'h0);
  c_od_pull:    cover property (port_five_pins_oe != 4'h0);
endmodule
`default_nettype wire

// >>> verif/mpgio_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mpgio_bench;
  import mpgio_pkg::*;
  // ****
  // Bus, pins and model state
  // ****
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb, xi;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [22:0] oe, o, pu, pin, en, ev, ae, av, dm, lm;
  logic [7:0]  ov[4];
  logic [3:0]  kr;
  logic [5:0]  sx;
  int          error_cnt, total_checks;
  logic [15:0] li[5] = '{P0_LATCH_IDX, P1_LATCH_IDX, P2_LATCH_IDX,
                         P3_LATCH_IDX, P5_LATCH_IDX};
  logic [15:0] di[5] = '{P0_DIR_IDX, P1_DIR_IDX, P2_DIR_IDX, P3_DIR_IDX,
                         P5_DIR_IDX};
  logic [15:0] oi[4] = '{PU0_IDX, PORT_TWO_PULLUP_OPTION_IDX, PORT_THREE_PULLUP_OPTION_IDX, KRM_IDX};
  logic [7:0]  om[4] = '{PU0_MASK, PORT_TWO_PULLUP_OPTION_MASK, PORT_THREE_PULLUP_OPTION_MASK, KRM_MASK};
  int          lo[5] = '{P0_LO, P1_LO, P2_LO, P3_LO, P5_LO};
  int          wd[5] = '{4, 4, 7, 4, 4};

  mpgio_top #(.P5_MASK_PULLUP(4'hA), .FLASH_VARIANT(1'b0)) uut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_zero_pins_i(pin[3:0]), .port_zero_pins_o(o[3:0]),
    .port_zero_pins_oe(oe[3:0]), .port_zero_pullup(pu[3:0]),
    .port_one_pins_i(pin[7:4]), .port_one_pins_o(o[7:4]),
    .port_one_pins_oe(oe[7:4]), .port_one_pullup(pu[7:4]),
    .port_two_pins_i(pin[14:8]), .port_two_pins_o(o[14:8]),
    .port_two_pins_oe(oe[14:8]), .port_two_pullup(pu[14:8]),
    .port_three_pins_i(pin[18:15]), .port_three_pins_o(o[18:15]),
    .port_three_pins_oe(oe[18:15]), .port_three_pullup(pu[18:15]),
    .port_five_pins_i(pin[22:19]), .port_five_pins_o(o[22:19]),
    .port_five_pins_oe(oe[22:19]), .port_five_pullup(pu[22:19]),
    .port_two_alt_en(ae[14:8]), .port_two_alt_out(av[14:8]),
    .port_three_alt_en(ae[18:15]), .port_three_alt_out(av[18:15]),
    .key_return_inputs(kr), .serial_a_clock(sx[0]), .serial_a_in(sx[1]),
    .serial_b_clock(sx[2]), .serial_b_in(sx[3]), .ext_interrupt_in(xi),
    .capture_input(sx[4]), .timer_c_input(sx[5]));
  mpgio_pins far (.aclk, .oe, .o, .pu, .ext_en(en), .ext_v(ev), .pin);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] d);
    logic a = 0, w = 0;
    s_axi_awaddr <= {ix, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (!w && s_axi_wready) s_axi_wvalid <= 1'b0;
      a = a | s_axi_awready;
      w = w | s_axi_wready;
    end
    // Response ready stays high; every call drives it high again along with the valids
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask
  task automatic rd(input logic [15:0] ix);
    s_axi_araddr <= {ix, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic check_pins();
    logic [22:0] pe, pue, pv, df;
    logic [9:0]  sd;
    int m;
    pue = dm & {4'hA, ov[2][3:0], ov[1][6:0], {4{ov[0][1]}},
                {4{ov[0][0] | ov[3][0]}}};
    pe = ~dm & ~(lm & 23'h78_0000);
    pv = (ae & av) | (~ae & lm);
    df = ~dm | en | pue;
    chk(32'(oe), 32'(pe));
    chk(32'(pu), 32'(pue));
    chk(32'(o & pe & 23'h07_FFFF), 32'(pv & pe & 23'h07_FFFF));
    chk(32'(o[22:19]), 32'h0);
    chk(32'(xi & df[18:15]), 32'(pin[18:15] & df[18:15]));
    sd = {df[3:0], df[16], df[15], df[13], df[11], df[10], df[8]};
    chk(32'({kr, sx} & sd), 32'({pin[3:0], pin[16], pin[15], pin[13],
        pin[11], pin[10], pin[8]} & sd));
    pv = (dm & ((en & ev) | (~en & pue))) | (~dm & lm);
    for (int p = 0; p < 5; p++) begin
      m = (1 << wd[p]) - 1;
      rd(di[p]);
      chk(rv, 32'((int'(dm >> lo[p]) & m) | (255 & ~m)));
      rd(li[p]);
      chk(rv & 32'(int'(df >> lo[p]) & m), 32'(int'(pv & df) >> lo[p] & m));
    end
    for (int q = 0; q < 4; q++) begin
      rd(oi[q]);
      chk(rv, 32'(ov[q] & om[q]));
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {aresetn, ce, s_axi_wstrb} = 6'h1F;
    aresetn = 1'b0;
    {en, ev, ae, av, lm} = '0;
    dm = '1;
    ov = '{default: 8'h00};
    void'($urandom(32'h957e_a45c));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check_pins();
    wr(16'h0001, 8'h5A);
    chk(32'(rs), 32'(RESP_SLVE));
    rd(16'h0001);
    chk(rv, 32'h0);
    chk(32'(rs), 32'(RESP_SLVE));
    repeat (25) begin
      {en, ev} <= {23'($urandom), 23'($urandom)};
      {ae, av} <= {23'($urandom) & 23'h07_FF00, 23'($urandom)};
      {dm, lm} = {23'($urandom), 23'($urandom)};
      for (int p = 0; p < 5; p++) begin
        wr(di[p], 8'(dm >> lo[p]));
        wr(li[p], 8'(lm >> lo[p]));
      end
      for (int q = 0; q < 4; q++) begin
        ov[q] = 8'($urandom);
        wr(oi[q], ov[q]);
      end
      repeat (5) @(posedge aclk);
      check_pins();
    end
    // Freeze: readies drop, pins and registers keep their state
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'({s_axi_awready, s_axi_arready}), 32'h0);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    check_pins();
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> verif/mpgio_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Circuitry outside the pins
// ****
module mpgio_pins (
  // Clock
  input  wire logic        aclk,
  // Block side
  input  wire logic [22:0] oe,
  input  wire logic [22:0] o,
  input  wire logic [22:0] pu,
  // Bench side
  input  wire logic [22:0] ext_en,
  input  wire logic [22:0] ext_v,
  output logic      [22:0] pin
);
  logic [22:0] float_q = 23'h55_5555;
  // A released line with no pull-up wanders, so it never reads as a level
  always @(posedge aclk) float_q <= ~pin;
  // Block drive wins; an open-drain pin only ever pulls low
  assign pin = (oe & o) | (~oe & ((ext_en & ext_v)
               | (~ext_en & (pu | float_q))));
endmodule
`default_nettype wire
